// File: logic/ezo_pkg.sv
// Package: constants, register map and types of the encoder pulse output block
package ezo_pkg;
   // Core clock
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PER_MS = CLK_HZ / 1000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   // Power-up initialization time
   localparam int INIT_BASE_MS = 1500;
   localparam int WAIT_STEP_MS = 100;
   localparam int INIT_BASE_CYC = INIT_BASE_MS * CLK_PER_MS;
   localparam int WAIT_STEP_CYC = WAIT_STEP_MS * CLK_PER_MS;
   // Setting ranges
   localparam logic [6:0] WAIT_MAX = 7'h64;
   localparam logic [14:0] ENCZ_MAX = 15'h7FFF;
   localparam logic [8:0] ZMIN_MAX_US = 9'h190;
   localparam logic [28:0] SER_INT_MAX = 29'h10000000;
   localparam int POS_W = 32;
   // Register byte addresses
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_WAIT = 8'h04;
   localparam logic [7:0] ADDR_ENCZ = 8'h08;
   localparam logic [7:0] ADDR_ZMIN = 8'h0C;
   localparam logic [7:0] ADDR_SINT = 8'h10;
   localparam logic [7:0] ADDR_ORIG = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;
   // Field positions
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_REGEN_BIT = 4;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_PEND_BIT = 1;
   localparam int STAT_Z_BIT = 2;
   // Reset values
   localparam logic [1:0] RST_SRC = 2'h0;
   localparam logic RST_REGEN = 1'b0;
   localparam logic [6:0] RST_WAIT = 7'h00;
   localparam logic [14:0] RST_ENCZ = 15'h0000;
   localparam logic [8:0] RST_ZMIN = 9'h000;
   localparam logic [28:0] RST_SINT = 29'h00000000;
   localparam logic [31:0] RST_ORIG = 32'h00000000;
   // Pulse source of the output stage
   typedef enum logic [1:0] {
      EZO_SRC_MOTOR,
      EZO_SRC_PARALLEL,
      EZO_SRC_SERIAL
   } ezo_src_type;
endpackage

// File: logic/ezo_ser_if.sv
// Interface: link between output stage and serial scale Z generator
`timescale 1ns/1ns
interface ezo_ser_if;
   import ezo_pkg::*;
   logic restart;
   logic a_step;
   logic dir_up;
   logic [POS_W-1:0] pos;
   logic [POS_W-1:0] origin;
   logic [28:0] interval;
   logic z_evt;
   logic found;
   modport gen(input restart, a_step, dir_up, pos, origin, interval, output z_evt, found);
   modport ctl(output restart, a_step, dir_up, pos, origin, interval, input z_evt, found);
endinterface

// File: logic/ezo_serial_z.sv
// Serial absolute scale Z generator: origin crossing and A-pulse interval
`timescale 1ns/1ns
module ezo_serial_z import ezo_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   ezo_ser_if.gen sif
);
   logic found_q, found_d;
   logic [28:0] cnt_q, cnt_d;
   logic prev_sign_q, prev_sign_d;
   logic prev_nz_q, prev_nz_d;
   logic evt_q, evt_d;
   logic [POS_W-1:0] diff;
   logic hit;

   // Distance to origin; a hit is landing on it or a sign flip across it
   assign diff = sif.pos - sif.origin;
   assign hit = (diff == '0) || (prev_nz_q && (diff[POS_W-1] != prev_sign_q));

   // Checked only on A steps so that Z lines up with the A phase
   always_comb begin
      found_d = found_q;
      cnt_d = cnt_q;
      prev_sign_d = prev_sign_q;
      prev_nz_d = prev_nz_q;
      evt_d = 1'b0;
      if (sif.restart) begin
         found_d = 1'b0;
         cnt_d = '0;
         prev_nz_d = 1'b0;
      end else if (sif.a_step) begin
         prev_sign_d = diff[POS_W-1];
         prev_nz_d = (diff != '0);
         if (sif.interval == '0) begin
            evt_d = hit;
         end else if (!found_q) begin
            if (hit) begin
               found_d = 1'b1;
               cnt_d = '0;
               evt_d = 1'b1;
            end
         end else if (sif.dir_up) begin
            // Interval counted in whole A pulses, not quadrature edges
            cnt_d = (cnt_q == sif.interval - 29'h1) ? '0 : cnt_q + 29'h1;
            evt_d = (cnt_q == sif.interval - 29'h1);
         end else begin
            cnt_d = (cnt_q == '0) ? sif.interval - 29'h1 : cnt_q - 29'h1;
            evt_d = (cnt_q == 29'h1) || (sif.interval == 29'h1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         found_q <= 1'b0;
         cnt_q <= '0;
         prev_sign_q <= 1'b0;
         prev_nz_q <= 1'b0;
         evt_q <= 1'b0;
      end else begin
         found_q <= found_d;
         cnt_q <= cnt_d;
         prev_sign_q <= prev_sign_d;
         prev_nz_q <= prev_nz_d;
         evt_q <= evt_d;
      end
   end

   assign sif.z_evt = evt_q;
   assign sif.found = found_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_zero_only_mode: assert property (
      (sif.a_step && !sif.restart && sif.interval == '0 && diff != '0 && !hit) |=> !sif.z_evt)
      else $error("Z emitted away from origin with zero interval");
   a_first_at_origin: assert property (
      (sif.a_step && !sif.restart && !found_q && sif.interval != '0)
         |=> (sif.z_evt == $past(hit)) && (found_q == $past(hit)))
      else $error("first Z not tied to origin crossing");
   a_period_count: assert property (
      (sif.a_step && !sif.restart && found_q && sif.dir_up && sif.interval != '0
         && cnt_q == sif.interval - 29'h1) |=> sif.z_evt && cnt_q == '0)
      else $error("periodic Z missing after set A pulse count");
endmodule

// File: logic/ezo_top.sv
// Encoder and external scale pulse output stage with Z generation
// Functional notes
// - Outputs stay quiet until 1.5 s plus the wait setting times 0.1 s have passed.
// - Motor Z pulse width is extended by the set number of divided A pulses.
// - A scale Z pulse is held high for at least the set minimum time.
// - The serial scale Z interval is counted in A pulses, before quadrature.
// - With zero interval, serial Z is only emitted at the origin.
// - Otherwise the first Z comes at the first origin crossing, then every interval.
// - The origin used for that first Z is the programmed offset position.
// - Method 0 passes the parallel scale A, B and Z straight through.
// - Method 1 outputs A and B rebuilt from the parallel scale signals.
// - In method 1 the parallel scale Z still goes straight to the output.
// - Settings written by software take effect only at the next power-on load.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
module ezo_top import ezo_pkg::*; #(
   parameter int P_BASE_CYC = INIT_BASE_CYC,
   parameter int P_STEP_CYC = WAIT_STEP_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_power_cycle,
   input wire logic i_enc_a,
   input wire logic i_enc_b,
   input wire logic i_enc_z_evt,
   input wire logic i_ext_a,
   input wire logic i_ext_b,
   input wire logic i_ext_z,
   input wire logic i_ser_a,
   input wire logic i_ser_b,
   input wire logic [POS_W-1:0] i_ser_pos,
   output logic o_out_a,
   output logic o_out_b,
   output logic o_out_z,
   output logic o_init_done
);
   // Wait total must fit 32 bits unsigned
   if (P_BASE_CYC < 1 || P_STEP_CYC < 1 || P_STEP_CYC > 20_000_000) begin : g_chk
      $error("ezo_top: initialization counts out of range");
   end

   // Software copies of settings
   logic [1:0] src_q, src_d;
   logic regen_q, regen_d;
   logic [6:0] wait_q, wait_d;
   logic [14:0] encz_q, encz_d;
   logic [8:0] zmin_q, zmin_d;
   logic [28:0] sint_q, sint_d;
   logic [31:0] orig_q, orig_d;
   logic pend_q, pend_d;
   // Settings in force since the last power-on load
   logic [1:0] a_src_q;
   logic a_regen_q;
   logic [6:0] a_wait_q;
   logic [14:0] a_encz_q;
   logic [8:0] a_zmin_q;
   logic [28:0] a_sint_q;
   logic [31:0] a_orig_q;
   logic boot_q;
   logic load;
   ezo_src_type src_e;

   // Power-on load: first cycle after reset or a control power cycle
   assign load = boot_q || i_power_cycle;
   assign src_e = ezo_src_type'(a_src_q);

   // Register writes: out-of-range values saturate, except a source of 3, which falls back to the reset source
   always_comb begin
      src_d = src_q;
      regen_d = regen_q;
      wait_d = wait_q;
      encz_d = encz_q;
      zmin_d = zmin_q;
      sint_d = sint_q;
      orig_d = orig_q;
      pend_d = load ? 1'b0 : pend_q;
      if (i_wr) begin
         pend_d = 1'b1; // Write to a mapped register wins over the clearing load
         case (i_addr)
            ADDR_CFG: begin
               src_d = (i_wdata[CFG_SRC_LSB+:2] == 2'h3) ? RST_SRC : i_wdata[CFG_SRC_LSB+:2];
               regen_d = i_wdata[CFG_REGEN_BIT];
            end
            ADDR_WAIT: wait_d = (i_wdata > 32'(WAIT_MAX)) ? WAIT_MAX : i_wdata[6:0];
            ADDR_ENCZ: encz_d = (i_wdata > 32'(ENCZ_MAX)) ? ENCZ_MAX : i_wdata[14:0];
            ADDR_ZMIN: zmin_d = (i_wdata > 32'(ZMIN_MAX_US)) ? ZMIN_MAX_US : i_wdata[8:0];
            ADDR_SINT: sint_d = (i_wdata > 32'(SER_INT_MAX)) ? SER_INT_MAX : i_wdata[28:0];
            ADDR_ORIG: orig_d = i_wdata;
            default: pend_d = load ? 1'b0 : pend_q;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         src_q <= RST_SRC;
         regen_q <= RST_REGEN;
         wait_q <= RST_WAIT;
         encz_q <= RST_ENCZ;
         zmin_q <= RST_ZMIN;
         sint_q <= RST_SINT;
         orig_q <= RST_ORIG;
         pend_q <= 1'b0;
      end else begin
         src_q <= src_d;
         regen_q <= regen_d;
         wait_q <= wait_d;
         encz_q <= encz_d;
         zmin_q <= zmin_d;
         sint_q <= sint_d;
         orig_q <= orig_d;
         pend_q <= pend_d;
      end
   end

   // Settings in force change only on the power-on load
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         boot_q <= 1'b1;
         a_src_q <= RST_SRC;
         a_regen_q <= RST_REGEN;
         a_wait_q <= RST_WAIT;
         a_encz_q <= RST_ENCZ;
         a_zmin_q <= RST_ZMIN;
         a_sint_q <= RST_SINT;
         a_orig_q <= RST_ORIG;
      end else begin
         boot_q <= 1'b0;
         if (load) begin
            a_src_q <= src_q;
            a_regen_q <= regen_q;
            a_wait_q <= wait_q;
            a_encz_q <= encz_q;
            a_zmin_q <= zmin_q;
            a_sint_q <= sint_q;
            a_orig_q <= orig_q;
         end
      end
   end

   // Initialization delay counter
   logic [31:0] init_cnt_q, init_cnt_d;
   logic done_q, done_d;
   logic [31:0] init_tgt;
   assign init_tgt = 32'(P_BASE_CYC) + 32'(a_wait_q) * 32'(P_STEP_CYC);

   always_comb begin
      init_cnt_d = init_cnt_q;
      done_d = done_q;
      if (load) begin
         init_cnt_d = '0;
         done_d = 1'b0;
      end else if (!done_q) begin
         init_cnt_d = init_cnt_q + 32'h1;
         done_d = (init_cnt_q == init_tgt - 32'h1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         init_cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         init_cnt_q <= init_cnt_d;
         done_q <= done_d;
      end
   end

   // Parallel scale pins come from outside: two flip-flops before use
   logic [2:0] ext_s1_q, ext_s2_q, ext_p_q;
   logic enc_a_p_q, ser_a_p_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ext_s1_q <= 3'h0;
         ext_s2_q <= 3'h0;
         ext_p_q <= 3'h0;
         enc_a_p_q <= 1'b0;
         ser_a_p_q <= 1'b0;
      end else begin
         ext_s1_q <= {i_ext_z, i_ext_b, i_ext_a};
         ext_s2_q <= ext_s1_q;
         ext_p_q <= ext_s2_q;
         enc_a_p_q <= i_enc_a;
         ser_a_p_q <= i_ser_a;
      end
   end

   // Quadrature rebuild: index {B, A^B} steps by one per valid edge
   logic [1:0] ph_q, ph_d;
   logic [1:0] idx_now, idx_prev, idx_step;
   assign idx_now = {ext_s2_q[1], ext_s2_q[1] ^ ext_s2_q[0]};
   assign idx_prev = {ext_p_q[1], ext_p_q[1] ^ ext_p_q[0]};
   assign idx_step = idx_now - idx_prev;

   // Double steps are glitches and dropped rather than guessed
   always_comb begin
      ph_d = ph_q;
      if (!a_regen_q || load) begin
         ph_d = idx_now; // Track the pins so a switch to rebuild starts aligned
      end else if (idx_step == 2'h1) begin
         ph_d = ph_q + 2'h1;
      end else if (idx_step == 2'h3) begin
         ph_d = ph_q - 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_d;
      end
   end

   // Serial scale Z generator
   ezo_ser_if ser_if();
   assign ser_if.restart = load;
   assign ser_if.a_step = i_ser_a & ~ser_a_p_q;
   assign ser_if.dir_up = ~i_ser_b;
   assign ser_if.pos = i_ser_pos;
   assign ser_if.origin = a_orig_q;
   assign ser_if.interval = a_sint_q;

   ezo_serial_z u_serial_z (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .sif(ser_if.gen)
   );

   // Motor Z width and scale Z minimum width stretchers
   logic mz_q, mz_d;
   logic [14:0] mz_cnt_q, mz_cnt_d;
   logic [14:0] st_cnt_q, st_cnt_d;
   logic [14:0] zmin_cyc;
   logic st_trig;
   assign zmin_cyc = 15'(a_zmin_q) * 15'(CLK_PER_US);
   assign st_trig = (src_e == EZO_SRC_PARALLEL) ? (ext_s2_q[2] & ~ext_p_q[2]) :
                    (src_e == EZO_SRC_SERIAL) ? ser_if.z_evt : 1'b0;

   always_comb begin
      mz_d = mz_q;
      mz_cnt_d = mz_cnt_q;
      st_cnt_d = st_cnt_q;
      if (i_enc_z_evt) begin
         mz_d = 1'b1;
         mz_cnt_d = a_encz_q;
      end else if (mz_q && i_enc_a && !enc_a_p_q) begin
         mz_d = (mz_cnt_q != '0);
         mz_cnt_d = (mz_cnt_q == '0) ? '0 : mz_cnt_q - 15'h1;
      end
      if (st_trig) begin
         // Zero setting still gives one clock so a serial Z is never lost
         st_cnt_d = (zmin_cyc == '0) ? 15'h1 : zmin_cyc;
      end else if (st_cnt_q != '0) begin
         st_cnt_d = st_cnt_q - 15'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mz_q <= 1'b0;
         mz_cnt_q <= '0;
         st_cnt_q <= '0;
      end else begin
         mz_q <= mz_d;
         mz_cnt_q <= mz_cnt_d;
         st_cnt_q <= st_cnt_d;
      end
   end

   // Output selection; all outputs retimed on the core clock
   logic a_d, b_d, z_d;
   logic [31:0] rdata_d;
   always_comb begin
      a_d = 1'b0;
      b_d = 1'b0;
      z_d = 1'b0;
      unique case (src_e)
         EZO_SRC_MOTOR: begin
            a_d = i_enc_a;
            b_d = i_enc_b;
            z_d = mz_q | i_enc_z_evt;
         end
         EZO_SRC_PARALLEL: begin
            a_d = a_regen_q ? (ph_q[1] ^ ph_q[0]) : ext_s2_q[0];
            b_d = a_regen_q ? ph_q[1] : ext_s2_q[1];
            z_d = ext_s2_q[2] | (st_cnt_q != '0);
         end
         EZO_SRC_SERIAL: begin
            a_d = i_ser_a;
            b_d = i_ser_b;
            z_d = (st_cnt_q != '0);
         end
         default: begin
            a_d = 1'b0;
            b_d = 1'b0;
            z_d = 1'b0;
         end
      endcase
      if (!done_q) begin
         a_d = 1'b0;
         b_d = 1'b0;
         z_d = 1'b0;
      end
      rdata_d = '0;
      if (i_rd) begin
         case (i_addr)
            ADDR_CFG: rdata_d = {27'h0, regen_q, 2'h0, src_q};
            ADDR_WAIT: rdata_d = {25'h0, wait_q};
            ADDR_ENCZ: rdata_d = {17'h0, encz_q};
            ADDR_ZMIN: rdata_d = {23'h0, zmin_q};
            ADDR_SINT: rdata_d = {3'h0, sint_q};
            ADDR_ORIG: rdata_d = orig_q;
            ADDR_STAT: begin
               rdata_d[STAT_DONE_BIT] = done_q;
               rdata_d[STAT_PEND_BIT] = pend_q;
               rdata_d[STAT_Z_BIT] = o_out_z;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_out_a <= 1'b0;
         o_out_b <= 1'b0;
         o_out_z <= 1'b0;
         o_init_done <= 1'b0;
         o_rdata <= '0;
      end else begin
         o_out_a <= a_d;
         o_out_b <= b_d;
         o_out_z <= z_d;
         o_init_done <= done_q;
         o_rdata <= rdata_d;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_par_direct;
      src_e == EZO_SRC_PARALLEL && !a_regen_q && done_q;
   endsequence
   sequence s_par_regen;
      (src_e == EZO_SRC_PARALLEL && a_regen_q && done_q && !load)[*2];
   endsequence

   a_init_quiet: assert property (
      (!done_q && $past(!done_q)) |=> !o_out_a && !o_out_b && !o_out_z)
      else $error("outputs active before initialization ended");
   a_init_time_end: assert property (
      $rose(done_q) |-> $past(init_cnt_q) == init_tgt - 32'h1)
      else $error("initialization ended at wrong count");
   a_motor_z_start: assert property (
      (i_enc_z_evt && done_q && src_e == EZO_SRC_MOTOR && !load) |=> o_out_z ##1 o_out_z)
      else $error("motor Z not raised after origin event");
   a_zmin_hold: assert property (
      (st_trig && done_q && !load) |=> (st_cnt_q != '0) ##1 o_out_z)
      else $error("scale Z shorter than the minimum width");
   a_direct_pass: assert property (
      (s_par_direct and !load) |=> o_out_a == $past(ext_s2_q[0]) && o_out_b == $past(ext_s2_q[1]))
      else $error("direct method does not pass A and B");
   a_regen_single_edge: assert property (
      s_par_regen |=> !((o_out_a != $past(o_out_a)) && (o_out_b != $past(o_out_b))))
      else $error("rebuilt quadrature changed both phases at once");
   a_z_direct_path: assert property (
      (src_e == EZO_SRC_PARALLEL && done_q && ext_s2_q[2] && !load) |=> o_out_z)
      else $error("parallel scale Z not passed through");
   a_cfg_deferred: assert property (
      (!load && i_wr && i_addr == ADDR_WAIT) |=> a_wait_q == $past(a_wait_q))
      else $error("setting took effect before power-on load");
endmodule

// File: verif/ezo_host_model.sv
// Host counter model: measures the width of each Z pulse it receives
`timescale 1ns/1ns
module ezo_host_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_z,
   output int o_z_width
);
   int run;
   // Run length of Z high, latched on the fall; a counter card sees whole cycles only
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         run <= 0;
         o_z_width <= 0;
      end else if (i_z === 1'h1) begin
         run <= run + 1;
      end else begin
         if (run != 0) begin
            o_z_width <= run;
         end
         run <= 0;
      end
   end
endmodule

// File: verif/test_encoder_pulse_output_z_phase.sv
// Self-checking bench of the encoder pulse output stage
`timescale 1ns/1ns
module test_encoder_pulse_output_z_phase;
   import ezo_pkg::*;
   localparam int BASE = 20;
   localparam int STEP = 3;
   localparam int LIMIT = 20000;
   logic i_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'h0, i_rd = 1'h0, i_power_cycle = 1'h0;
   logic i_enc_a = 1'h1, i_enc_b = 1'h0, i_enc_z_evt = 1'h0;
   logic i_ext_a = 1'h0, i_ext_b = 1'h0, i_ext_z = 1'h0;
   logic i_ser_a = 1'h0, i_ser_b = 1'h0;
   logic [31:0] i_ser_pos = 32'h0;
   logic [31:0] o_rdata;
   logic o_out_a, o_out_b, o_out_z, o_init_done;
   logic [31:0] r;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'hACC5759D;
   int z_w, sint, orig, found, cnt, ez, d, p;

   // Free-running core clock
   always #10 i_clk = ~i_clk;

   ezo_top #(.P_BASE_CYC(BASE), .P_STEP_CYC(STEP)) ezo_top_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_power_cycle(i_power_cycle),
      .i_enc_a(i_enc_a), .i_enc_b(i_enc_b), .i_enc_z_evt(i_enc_z_evt),
      .i_ext_a(i_ext_a), .i_ext_b(i_ext_b), .i_ext_z(i_ext_z),
      .i_ser_a(i_ser_a), .i_ser_b(i_ser_b), .i_ser_pos(i_ser_pos),
      .o_out_a(o_out_a), .o_out_b(o_out_b), .o_out_z(o_out_z), .o_init_done(o_init_done));

   ezo_host_model ezo_host_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_z(o_out_z),
      .o_z_width(z_w));

   // Verdict and end of run, shared by main sequence and hang guard
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Bus cycles: one-cycle strobes launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
      // Idle edge so back-to-back calls never reassign the strobe in one step
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 chk(o_rdata, e);
      @(posedge i_clk);
   endtask

   // Counts edges until init is over; outputs are checked quiet at the fourth edge
   task automatic init_wait(input int lo);
      int n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
         if (n == 4) chk(32'({o_out_a, o_out_b, o_out_z}), 32'h0);
      end while (o_init_done !== 1'h1 && n < 400);
      chk(32'(n >= lo && n <= lo + 5), 32'h1);
      @(posedge i_clk);
   endtask

   // Settings load only at a power-on event; pending flag shows the gap
   task automatic cfg(input logic [31:0] c, z, s, o, e);
      wr(ADDR_CFG, c);
      wr(ADDR_ZMIN, z);
      wr(ADDR_SINT, s);
      wr(ADDR_ORIG, o);
      wr(ADDR_ENCZ, e);
      rd(ADDR_STAT, 32'h3);
      i_power_cycle <= 1'h1;
      @(posedge i_clk);
      i_power_cycle <= 1'h0;
      repeat (3) @(posedge i_clk);
      init_wait(BASE + 10 * STEP - 3);
      rd(ADDR_STAT, 32'h1);
   endtask

   // Hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_fail++;
         print_verdict();
      end
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'h1;
      init_wait(BASE);
      for (int a = 0; a <= 20; a += 4) rd(8'(a), 32'h0);
      rd(8'h1C, 32'h0);
      wr(ADDR_WAIT, 32'hC8);
      rd(ADDR_WAIT, 32'h64);
      wr(ADDR_WAIT, 32'hA);
      rd(ADDR_WAIT, 32'hA);
      // Motor Z held until the (ENCZ+1)-th divided A rise
      for (int e = 0; e <= 2; e += 2) begin
         cfg(32'h0, 32'h0, 32'h0, 32'h0, e);
         i_enc_a <= 1'h0;
         i_enc_z_evt <= 1'h1;
         @(posedge i_clk);
         i_enc_z_evt <= 1'h0;
         for (int k = 0; k <= e; k++) begin
            repeat (4) @(posedge i_clk);
            #1 chk(32'(o_out_z), 32'h1);
            i_enc_a <= 1'h1;
            repeat (4) @(posedge i_clk);
            i_enc_a <= 1'h0;
         end
         repeat (2) @(posedge i_clk);
         #1 chk(32'(o_out_z), 32'h0);
         @(posedge i_clk);
      end
      // Parallel scale, direct then rebuilt; rebuilt gets single quadrature steps
      for (int m = 0; m < 2; m++) begin
         cfg(32'(m * 16 + 1), 32'h0, 32'h0, 32'h0, 32'h0);
         for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            if (m == 0) begin
               i_ext_a <= r[0];
               i_ext_b <= r[1];
            end else if (r[0]) begin
               i_ext_a <= ~i_ext_a;
            end else begin
               i_ext_b <= ~i_ext_b;
            end
            i_ext_z <= r[2] & r[3];
            repeat (6) @(posedge i_clk);
            #1 chk(32'({o_out_a, o_out_b, o_out_z}), 32'({i_ext_a, i_ext_b, i_ext_z}));
         end
         i_ext_a <= 1'h0;
         i_ext_b <= 1'h0;
         i_ext_z <= 1'h0;
         @(posedge i_clk);
      end
      // Short scale Z stretched to the minimum; later write not yet in force
      cfg(32'h1, 32'h1, 32'h0, 32'h0, 32'h0);
      wr(ADDR_ZMIN, 32'h0);
      i_ext_z <= 1'h1;
      repeat (2) @(posedge i_clk);
      i_ext_z <= 1'h0;
      repeat (70) @(posedge i_clk);
      #1 chk(32'(z_w >= CLK_PER_US && z_w <= CLK_PER_US + 3), 32'h1);
      @(posedge i_clk);
      // Serial scale: model of origin search and A-pulse interval, both directions
      for (int t = 0; t < 2; t++) begin
         sint = t ? 0 : 4;
         orig = t ? 0 : 100;
         found = 0;
         cnt = 0;
         cfg(32'h2, 32'h0, sint, orig, 32'h0);
         // Sixteen steps up, then six down, back across a Z position when the interval is 4
         for (int s = 0; s < 22; s++) begin
            d = (s < 16) ? 1 : -1;
            p = (s < 16) ? orig - 5 + s : orig + 25 - s;
            i_ser_pos <= 32'(p);
            i_ser_a <= 1'h1;
            i_ser_b <= (d < 0);
            if (sint == 0 || found == 0) begin
               ez = (p == orig);
               found = ez;
            end else begin
               cnt = (cnt + d + sint) % sint;
               ez = (cnt == 0);
            end
            // Step, event, stretcher load, then Z stands for one cycle
            repeat (3) @(posedge i_clk);
            #1 chk(32'(o_out_z), 32'(ez));
            i_ser_a <= 1'h0;
            repeat (3) @(posedge i_clk);
         end
      end
      print_verdict();
   end
endmodule
